/* File: rtl/embedded_memory_block.sv */
// embedded memory block: dual/quad-port ram, single-port ram and cam, apb setup
// assumes fabric ticks and enables are synchronous to pclk; apb master per amba
`timescale 1ns/1ps
`include "ram_cam_map.svh"
module embedded_memory_block #(
    parameter int AW = 12,
    parameter int DW = 32
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [11:0]      paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             glob_clr,
    input  wire logic             a_wr_tick,
    input  wire logic             a_rd_tick,
    input  wire logic             a_wce,
    input  wire logic             a_rce,
    input  wire logic             a_clr,
    input  wire logic [DW-1:0]    a_din,
    input  wire logic [AW-1:0]    a_waddr,
    input  wire logic             a_write_enable_line,
    input  wire logic [AW-1:0]    a_raddr,
    input  wire logic             a_read_enable_line,
    output logic [DW-1:0]         a_dout,
    input  wire logic             b_wr_tick,
    input  wire logic             b_rd_tick,
    input  wire logic             b_wce,
    input  wire logic             b_rce,
    input  wire logic             b_clr,
    input  wire logic [DW-1:0]    b_din,
    input  wire logic [AW-1:0]    b_waddr,
    input  wire logic             b_write_enable_line,
    input  wire logic [AW-1:0]    b_raddr,
    input  wire logic             b_read_enable_line,
    output logic [DW-1:0]         b_dout,
    input  wire logic [31:0]      cam_key,
    input  wire logic             cam_search,
    input  wire logic             cam_wr,
    input  wire logic [4:0]       cam_wr_idx,
    input  wire logic [31:0]      cam_wr_data,
    input  wire logic [31:0]      cam_wr_care,
    output logic                  cam_busy,
    output logic [15:0]           match_vec,
    output logic                  match_half,
    output logic                  match_valid,
    output logic                  match_found,
    output logic [4:0]            match_addr
);
    import ram_cam_pkg::*;

    localparam int ROWS = 128;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        mem_mode_t   mode;
        logic [2:0]  wsel;
        logic        b_shared;
        logic        enc_out;
        logic        split;
        logic [11:0] regsel;
        logic [31:0] apb_data;
        logic [31:0] apb_care;
        logic        apb_go;
        logic [4:0]  apb_idx;
        cam_state_t  cam_st;
        logic [31:0] w_data;
        logic [31:0] w_care;
        logic [4:0]  w_idx;
        logic [31:0] valid;
        logic [31:0] sav_vec;
        logic        sav_found;
        logic [4:0]  sav_addr;
        logic        busy;
        logic [15:0] m_vec;
        logic        m_half;
        logic        m_valid;
        logic        m_found;
        logic [4:0]  m_addr;
    } top_state_t;

    top_state_t q;
    top_state_t d;

    logic [DW-1:0] ram [ROWS];
    logic [31:0]   cam_data [`CAM_WORDS];
    logic [31:0]   cam_care [`CAM_WORDS];

    logic            a_go;
    logic            b_go;
    logic [AW-1:0]   a_wa;
    logic [AW-1:0]   b_wa;
    logic [AW-1:0]   a_ra;
    logic [AW-1:0]   b_ra;
    logic [DW-1:0]   a_wd;
    logic [DW-1:0]   b_wd;
    logic [DW-1:0]   a_rd;
    logic [DW-1:0]   b_rd;
    logic            b_wtick;
    logic            b_rtick;
    logic [31:0]     hit;
    logic [31:0]     enc_in;
    logic            enc_found;
    logic [4:0]      enc_idx;
    logic            cam_commit;
    logic            apb_acc;

    // row and bit offset of an address for the selected width
    function automatic logic [6:0] row_of(input logic [11:0] a, input logic [2:0] w,
                                          input logic split, input logic hi);
        logic [6:0] r;
        r = 7'h0;
        case (w)
            3'd0:    r = a[11:5];
            3'd1:    r = a[10:4];
            3'd2:    r = a[9:3];
            3'd3:    r = a[8:2];
            3'd4:    r = a[7:1];
            default: r = a[6:0];
        endcase
        // each single-port ram owns half the rows
        if (split) begin
            r[6] = hi;
        end
        return r;
    endfunction

    function automatic logic [4:0] off_of(input logic [11:0] a, input logic [2:0] w);
        logic [4:0] o;
        o = 5'h0;
        case (w)
            3'd0:    o = a[4:0];
            3'd1:    o = {a[3:0], 1'b0};
            3'd2:    o = {a[2:0], 2'b0};
            3'd3:    o = {a[1:0], 3'b0};
            3'd4:    o = {a[0], 4'b0};
            default: o = 5'h0;
        endcase
        return o;
    endfunction

    function automatic logic [31:0] wmask(input logic [2:0] w);
        logic [32:0] m;
        m = (33'h1 << (6'd1 << w)) - 33'h1;
        return m[31:0];
    endfunction

    // port b on its own or port a clocks
    assign b_wtick = q.b_shared ? a_wr_tick : b_wr_tick;
    assign b_rtick = q.b_shared ? a_rd_tick : b_rd_tick;

    mem_port #(.AW(AW), .DW(DW)) u_port_a (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (a_clr | glob_clr),
        .wr_tick (a_wr_tick),
        .rd_tick (a_rd_tick),
        .wce     (a_wce),
        .rce     (a_rce),
        .reg_sel (q.regsel[5:0]),
        .din     (a_din),
        .waddr   (a_waddr),
        .we      (a_write_enable_line),
        .raddr   (a_raddr),
        .re      (a_read_enable_line),
        .rdata   (a_rd),
        .wr_go   (a_go),
        .wr_addr (a_wa),
        .wr_data (a_wd),
        .rd_addr (a_ra),
        .dout    (a_dout)
    );

    mem_port #(.AW(AW), .DW(DW)) u_port_b (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (b_clr | glob_clr),
        .wr_tick (b_wtick),
        .rd_tick (b_rtick),
        .wce     (b_wce),
        .rce     (b_rce),
        .reg_sel (q.regsel[11:6]),
        .din     (b_din),
        .waddr   (b_waddr),
        .we      (b_write_enable_line),
        .raddr   (b_raddr),
        .re      (b_read_enable_line),
        .rdata   (b_rd),
        .wr_go   (b_go),
        .wr_addr (b_wa),
        .wr_data (b_wd),
        .rd_addr (b_ra),
        .dout    (b_dout)
    );

    always_comb begin
        logic [11:0] ra;
        logic [11:0] rb;
        ra   = (q.mode == MODE_SINGLE) ? a_wa : a_ra;
        rb   = (q.mode == MODE_SINGLE) ? b_wa : b_ra;
        a_rd = (ram[row_of(ra, q.wsel, q.split, 1'b0)] >> off_of(ra, q.wsel)) & wmask(q.wsel);
        b_rd = (ram[row_of(rb, q.wsel, q.split, 1'b1)] >> off_of(rb, q.wsel)) & wmask(q.wsel);
    end

    // port b is written last, so it wins a same-row clash
    always_ff @(posedge pclk) begin
        logic [6:0] r;
        logic [4:0] o;
        if (a_go) begin
            r = row_of(a_wa, q.wsel, q.split, 1'b0);
            o = off_of(a_wa, q.wsel);
            ram[r] <= (ram[r] & ~(wmask(q.wsel) << o)) | ((a_wd & wmask(q.wsel)) << o);
        end
        if (b_go) begin
            r = row_of(b_wa, q.wsel, q.split, 1'b1);
            o = off_of(b_wa, q.wsel);
            ram[r] <= (ram[r] & ~(wmask(q.wsel) << o)) | ((b_wd & wmask(q.wsel)) << o);
        end
    end

    // compare key against every stored word
    always_comb begin
        for (int i = 0; i < `CAM_WORDS; i++) begin
            hit[i] = q.valid[i] && (((cam_data[i] ^ cam_key) & cam_care[i]) == 32'h0);
        end
    end

    // fast mode searches 16 words only
    assign enc_in = (q.mode == MODE_CAM_FAST) ? {16'h0, hit[15:0]} : hit;

    match_encoder #(.N(`CAM_WORDS), .IW(5)) u_enc (
        .vec   (enc_in),
        .found (enc_found),
        .idx   (enc_idx)
    );

    // entry lands after two or three cycles
    assign cam_commit = (q.cam_st == CAM_WR2 && q.w_care == 32'hffffffff) ||
                        (q.cam_st == CAM_WR3);

    always_ff @(posedge pclk) begin
        if (cam_commit) begin
            cam_data[q.w_idx] <= q.w_data;
            cam_care[q.w_idx] <= q.w_care;
        end
    end

    assign apb_acc = psel && penable && !q.pready;

    always_comb begin
        d         = q;
        d.pready  = apb_acc;
        d.pslverr = 1'b0;
        d.m_valid = 1'b0;
        if (apb_acc) begin
            d.prdata = 32'h0;
            case (paddr)
                `CTRL_OFF: begin
                    d.prdata = {24'h0, q.split, q.enc_out, q.b_shared, q.wsel, q.mode};
                    if (pwrite) begin
                        d.mode     = mem_mode_t'(pwdata[`CTRL_MODE_LSB +: 2]);
                        d.wsel     = (pwdata[`CTRL_WSEL_LSB +: 3] > `WSEL_MAX) ?
                                     `WSEL_MAX : pwdata[`CTRL_WSEL_LSB +: 3];
                        d.b_shared = pwdata[`CTRL_BSHARE_BIT];
                        d.enc_out  = pwdata[`CTRL_ENC_BIT];
                        d.split    = pwdata[`CTRL_SPLIT_BIT];
                    end
                end
                `REGSEL_OFF: begin
                    d.prdata = {20'h0, q.regsel};
                    if (pwrite) begin
                        d.regsel = pwdata[11:0];
                    end
                end
                `STATUS_OFF: begin
                    d.prdata = {25'h0, q.sav_addr, q.sav_found, q.busy};
                end
                `CAMDATA_OFF: begin
                    d.prdata = q.apb_data;
                    if (pwrite) begin
                        d.apb_data = pwdata;
                    end
                end
                `CAMCARE_OFF: begin
                    d.prdata = q.apb_care;
                    if (pwrite) begin
                        d.apb_care = pwdata;
                    end
                end
                `CAMCMD_OFF: begin
                    d.prdata = {26'h0, q.apb_go, q.apb_idx};
                    if (pwrite && !q.apb_go) begin
                        d.apb_idx = pwdata[4:0];
                        d.apb_go  = 1'b1;
                    end
                end
                default: begin
                    d.pslverr = 1'b1;
                end
            endcase
        end
        case (q.cam_st)
            CAM_IDLE: begin
                if (cam_wr || q.apb_go) begin
                    d.w_data = cam_wr ? cam_wr_data : q.apb_data;
                    d.w_care = cam_wr ? cam_wr_care : q.apb_care;
                    d.w_idx  = cam_wr ? cam_wr_idx : q.apb_idx;
                    d.apb_go = cam_wr ? d.apb_go : 1'b0;
                    d.busy   = 1'b1;
                    d.cam_st = CAM_WR1;
                end else if (cam_search && q.mode[1]) begin
                    d.m_vec     = q.enc_out ? 16'h0 : hit[15:0];
                    d.m_half    = 1'b0;
                    d.m_valid   = 1'b1;
                    d.sav_vec   = hit;
                    d.sav_found = enc_found;
                    d.sav_addr  = enc_idx;
                    if (q.mode == MODE_CAM_FAST) begin
                        d.m_found = enc_found;
                        d.m_addr  = q.enc_out ? enc_idx : 5'h0;
                    end else begin
                        d.busy   = 1'b1;
                        d.cam_st = CAM_SRCH2;
                    end
                end
            end
            CAM_WR1: begin
                d.cam_st = CAM_WR2;
            end
            CAM_WR2: begin
                if (q.w_care == 32'hffffffff) begin
                    d.valid[q.w_idx] = 1'b1;
                    d.busy           = 1'b0;
                    d.cam_st         = CAM_IDLE;
                end else begin
                    d.cam_st = CAM_WR3;
                end
            end
            CAM_WR3: begin
                d.valid[q.w_idx] = 1'b1;
                d.busy           = 1'b0;
                d.cam_st         = CAM_IDLE;
            end
            CAM_SRCH2: begin
                d.m_vec   = q.enc_out ? 16'h0 : q.sav_vec[31:16];
                d.m_half  = 1'b1;
                d.m_valid = 1'b1;
                d.m_found = q.sav_found;
                d.m_addr  = q.enc_out ? q.sav_addr : 5'h0;
                d.busy    = 1'b0;
                d.cam_st  = CAM_IDLE;
            end
            default: begin
                d.cam_st = CAM_IDLE;
                d.busy   = 1'b0;
            end
        endcase
        if (glob_clr) begin
            d.m_vec   = 16'h0;
            d.m_found = 1'b0;
            d.m_addr  = 5'h0;
            d.m_half  = 1'b0;
        end
    end

    // chip reset clears control state but loads wsel with WSEL_MAX, apb_care with CAMCARE_RESET and cam_st with CAM_IDLE
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q          <= '0;
            q.mode     <= mem_mode_t'(`CTRL_RESET & 8'h03);
            q.wsel     <= `WSEL_MAX;
            q.regsel   <= `REGSEL_RESET;
            q.apb_care <= `CAMCARE_RESET;
            q.cam_st   <= CAM_IDLE;
        end else begin
            q <= d;
        end
    end

    assign prdata      = q.prdata;
    assign pready      = q.pready;
    assign pslverr     = q.pslverr;
    assign cam_busy    = q.busy;
    assign match_vec   = q.m_vec;
    assign match_half  = q.m_half;
    assign match_valid = q.m_valid;
    assign match_found = q.m_found;
    assign match_addr  = q.m_addr;

endmodule

/* File: rtl/match_encoder.sv */
// priority encoder for cam match vectors, lowest index wins
// assumes the caller registers the result
`timescale 1ns/1ps
module match_encoder #(
    parameter int N  = 32,
    parameter int IW = 5
) (
    input  wire logic [N-1:0]  vec,
    output logic               found,
    output logic [IW-1:0]      idx
);
    always_comb begin
        found = 1'b0;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (vec[i]) begin
                found = 1'b1;
                idx   = IW'(i);
            end
        end
    end

endmodule

/* File: rtl/mem_port.sv */
// one memory port: optional input registers on the write tick, read registers and
// output register on the read tick; assumes ticks are single-cycle strobes on pclk
`timescale 1ns/1ps
`include "ram_cam_map.svh"
module mem_port #(
    parameter int AW = 12,
    parameter int DW = 32
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          clr,
    input  wire logic          wr_tick,
    input  wire logic          rd_tick,
    input  wire logic          wce,
    input  wire logic          rce,
    input  wire logic [5:0]    reg_sel,
    input  wire logic [DW-1:0] din,
    input  wire logic [AW-1:0] waddr,
    input  wire logic          we,
    input  wire logic [AW-1:0] raddr,
    input  wire logic          re,
    input  wire logic [DW-1:0] rdata,
    output logic               wr_go,
    output logic [AW-1:0]      wr_addr,
    output logic [DW-1:0]      wr_data,
    output logic [AW-1:0]      rd_addr,
    output logic [DW-1:0]      dout
);
    import ram_cam_pkg::*;

    typedef struct packed {
        logic [DW-1:0] din;
        logic [AW-1:0] waddr;
        logic          we;
        logic [AW-1:0] raddr;
        logic          re;
        logic [DW-1:0] dout;
    } port_state_t;

    port_state_t q;
    port_state_t d;
    logic        we_e;
    logic        re_e;

    assign wr_data = reg_sel[`PSEL_DIN]   ? q.din   : din;
    assign wr_addr = reg_sel[`PSEL_WADDR] ? q.waddr : waddr;
    assign we_e    = reg_sel[`PSEL_WE]    ? q.we    : we;
    assign rd_addr = reg_sel[`PSEL_RADDR] ? q.raddr : raddr;
    assign re_e    = reg_sel[`PSEL_RE]    ? q.re    : re;
    assign dout    = q.dout;
    assign wr_go   = wr_tick & wce & we_e & ~clr;

    always_comb begin
        d = q;
        if (wr_tick && wce) begin
            d.din   = din;
            d.waddr = waddr;
            d.we    = we;
        end
        if (rd_tick && rce) begin
            d.raddr = raddr;
            d.re    = re;
        end
        if (reg_sel[`PSEL_DOUT] ? (rd_tick && rce && re_e) : 1'b1) begin
            d.dout = rdata;
        end
        if (clr) begin
            d = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

/* File: rtl/ram_cam_map.svh */
// register offsets, field positions, reset values and word counts of the memory block
// assumes a 32-bit apb slave with 12-bit byte addresses and one 25 mhz clock
//
// What this block does
// - quad-port ram takes four independent clocks
// - port a write clock drives write registers
// - port a read clock drives read registers
// - port b uses own or port a clocks
// - per-port read enable, write enable, clear
// - single-port mode holds two independent rams
// - single ram width 1 to 32 bits
// - local, global or chip reset clears registers
// - cam returns address of presented word
// - match as encoded address or vector
// - multiple-match shows 16 matches per cycle
// - encoded result from separate priority encoder
// - fast mode: one cycle, 16 words
// - cam write two cycles, three with don't-cares
// - cam loadable at setup and in operation
// - optional register on each port path
// - input and output registers on different clocks
`ifndef RAM_CAM_MAP_SVH
`define RAM_CAM_MAP_SVH

`define CTRL_OFF        12'h000
`define REGSEL_OFF      12'h004
`define STATUS_OFF      12'h008
`define CAMDATA_OFF     12'h00c
`define CAMCARE_OFF     12'h010
`define CAMCMD_OFF      12'h014

`define CTRL_MODE_LSB   0
`define CTRL_WSEL_LSB   2
`define CTRL_BSHARE_BIT 5
`define CTRL_ENC_BIT    6
`define CTRL_SPLIT_BIT  7
`define CTRL_RESET      8'h14

`define REGSEL_RESET    12'h000
`define CAMCARE_RESET   32'hffffffff
`define WSEL_MAX        3'd5

`define PSEL_DIN        0
`define PSEL_DOUT       1
`define PSEL_RADDR      2
`define PSEL_WADDR      3
`define PSEL_WE         4
`define PSEL_RE         5

`define CAM_WORDS       32
`define CAM_FAST_WORDS  16
`define CAM_OUTS        16

`endif

/* File: rtl/ram_cam_pkg.sv */
// types shared by the memory block modules
// assumes ram_cam_map.svh supplies the numeric constants
package ram_cam_pkg;

    typedef enum logic [1:0] {
        MODE_RAM       = 2'b00,
        MODE_SINGLE    = 2'b01,
        MODE_CAM_MULTI = 2'b10,
        MODE_CAM_FAST  = 2'b11
    } mem_mode_t;

    typedef enum logic [4:0] {
        CAM_IDLE  = 5'b00001,
        CAM_WR1   = 5'b00010,
        CAM_WR2   = 5'b00100,
        CAM_WR3   = 5'b01000,
        CAM_SRCH2 = 5'b10000
    } cam_state_t;

endpackage

/* File: tb/cam_feeder.sv */
// fabric-side model that writes words into the cam table
// assumes put is called just after a rising edge of pclk
`timescale 1ns/1ps
module cam_feeder (
    input  wire logic   pclk,
    input  wire logic   cam_busy,
    output logic        cam_wr,
    output logic [4:0]  cam_wr_idx,
    output logic [31:0] cam_wr_data,
    output logic [31:0] cam_wr_care
);
    initial begin
        cam_wr = 0;
        {cam_wr_idx, cam_wr_data, cam_wr_care} = '0;
    end
    task put(input logic [4:0] i, input logic [31:0] d, c);
        cam_wr <= 1;
        {cam_wr_idx, cam_wr_data, cam_wr_care} <= {i, d, c};
        @(posedge pclk) cam_wr <= 0;
        do @(posedge pclk); while (cam_busy !== 1'b0);
        // released lines show the inverse
        {cam_wr_idx, cam_wr_data, cam_wr_care} <= ~{i, d, c};
        @(posedge pclk);
    endtask
endmodule

/* File: tb/mem_block_chk_sva.sv */
// checker for apb answer timing, cam search and write timing, clears
// assumes binding to embedded_memory_block with its single clock pclk
`timescale 1ns/1ps
module mem_block_chk #(
    parameter int DW = 32
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          glob_clr,
    input wire logic          a_clr,
    input wire logic [DW-1:0] a_dout,
    input wire logic [DW-1:0] b_dout,
    input wire logic          cam_wr,
    input wire logic          cam_busy,
    input wire logic [15:0]   match_vec,
    input wire logic          match_half,
    input wire logic          match_valid
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_wait; psel && penable && !pready |=> pready; endproperty
    property p_one; pready |=> !pready; endproperty
    property p_err; pslverr |-> pready; endproperty
    property p_multi; match_valid && !match_half && cam_busy |=> match_valid && match_half;
    endproperty
    property p_wrbusy; cam_wr && !cam_busy |=> cam_busy; endproperty
    property p_busyend; $rose(cam_busy) |-> ##[1:4] !cam_busy; endproperty
    property p_gclr; glob_clr |=> a_dout == 0 && b_dout == 0 && match_vec == 0; endproperty
    property p_aclr; a_clr |=> a_dout == 0; endproperty
    property p_hold; (!glob_clr ##1 !match_valid) |-> $stable(match_vec); endproperty
    a_wait: assert property (p_wait) else $error("apb answer late");
    a_one: assert property (p_one) else $error("pready longer than one cycle");
    a_err: assert property (p_err) else $error("pslverr without pready");
    a_multi: assert property (p_multi) else $error("second half missing");
    a_wrbusy: assert property (p_wrbusy) else $error("cam write not taken");
    a_busyend: assert property (p_busyend) else $error("cam busy too long");
    a_gclr: assert property (p_gclr) else $error("global clear missed");
    a_aclr: assert property (p_aclr) else $error("port a clear missed");
    a_hold: assert property (p_hold) else $error("match vector moved");
    c_half: cover property (match_valid && match_half);
    c_err: cover property (pslverr);
    c_busy: cover property ($rose(cam_busy));
endmodule
bind embedded_memory_block mem_block_chk #(.DW(DW)) chk_u (.*);

/* File: tb/tb_top.sv */
// testbench: apb setup, ram ports, cam search and clears
// assumes the design and cam_feeder share pclk at 25 mhz
`timescale 1ns/1ps
`include "ram_cam_map.svh"
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, glob_clr = 0;
    logic a_wr_tick = 0, a_rd_tick = 0, a_wce = 0, a_rce = 0, a_clr = 0;
    logic b_wr_tick = 0, b_rd_tick = 0, b_wce = 0, b_rce = 0, b_clr = 0, cam_search = 0;
    logic a_write_enable_line = 0, a_read_enable_line = 0;
    logic b_write_enable_line = 0, b_read_enable_line = 0;
    logic [11:0] paddr = 0, a_waddr = 0, a_raddr = 0, b_waddr = 0, b_raddr = 0;
    logic [31:0] pwdata = 0, a_din = 0, b_din = 0, cam_key = 0;
    logic [31:0] prdata, a_dout, b_dout, cam_wr_data, cam_wr_care, r;
    logic        pready, pslverr, cam_busy, match_half, match_valid, match_found;
    logic        cam_wr, e, hv, f, h;
    logic [15:0] match_vec, v0, v1;
    logic [4:0]  match_addr, cam_wr_idx, ad;
    int          fails = 0, num_checks = 0, cyc = 0;
    always #20 pclk = ~pclk;
    embedded_memory_block dut_u (.*);
    cam_feeder feed_u (.*);
    task chk(input logic [63:0] s, x);
        num_checks++;
        if (s !== x) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task conclude;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        {r, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    // writes and reads never overlap, so no same-address collision
    task wr(input logic [1:0] t, en, input logic [11:0] a, input logic [31:0] d);
        {a_write_enable_line, b_write_enable_line, b_wr_tick, a_wr_tick} <= {2'b11, t};
        {b_wce, a_wce, a_waddr, b_waddr, a_din, b_din} <= {en, a, a, d, d};
        @(posedge pclk);
        {a_write_enable_line, b_write_enable_line, b_wr_tick, a_wr_tick} <= 0;
        @(posedge pclk);
    endtask
    task rd(input logic [1:0] t, input logic [11:0] a);
        {a_read_enable_line, b_read_enable_line, a_rce, b_rce, b_rd_tick, a_rd_tick} <= {4'hf, t};
        {a_raddr, b_raddr} <= {a, a};
        @(posedge pclk);
        {a_read_enable_line, b_read_enable_line, a_rce, b_rce, b_rd_tick, a_rd_tick} <= 0;
        @(posedge pclk);
    endtask
    task srch(input logic [31:0] k);
        {cam_key, cam_search} <= {k, 1'b1};
        @(posedge pclk) cam_search <= 0;
        do @(posedge pclk); while (match_valid !== 1'b1);
        v0 = match_vec;
        @(posedge pclk);
        {v1, hv, f, ad, h} = {match_vec, match_valid, match_found, match_addr, match_half};
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, `CTRL_OFF, 0);
        chk(r, 32'h14);
        apb(0, `CAMCARE_OFF, 0);
        chk(r, 32'hffffffff);
        apb(0, 12'h020, 0);
        chk(e, 1);
        $display("registers done");
        for (int w = 0; w < 6; w++) begin
            apb(1, `CTRL_OFF, 32'(w << 2));
            wr(2'b01, 2'b11, 0, '1);
            rd(2'b01, 0);
            chk(a_dout, 32'((64'h1 << (1 << w)) - 1));
        end
        wr(2'b10, 2'b11, 5, 32'hbeef);
        rd(2'b10, 5);
        chk(b_dout, 32'hbeef);
        rd(2'b01, 5);
        chk(a_dout, 32'hbeef);
        wr(2'b01, 2'b00, 5, 0);
        rd(2'b01, 5);
        chk(a_dout, 32'hbeef);
        apb(1, `CTRL_OFF, 32'h34);
        wr(2'b10, 2'b11, 5, 32'h66);
        rd(2'b01, 5);
        chk(a_dout, 32'hbeef);
        wr(2'b01, 2'b11, 5, 32'h77);
        rd(2'b01, 5);
        chk(b_dout, 32'h77);
        a_clr <= 1;
        @(posedge pclk) a_clr <= 0;
        @(negedge pclk);
        chk({a_dout, b_dout}, {32'h0, 32'h77});
        @(posedge pclk);
        // two single-port rams, split halves, read at write address
        apb(1, `CTRL_OFF, 32'h95);
        wr(2'b11, 2'b11, 3, 32'hab);
        wr(2'b01, 2'b11, 3, 32'hcd);
        rd(2'b11, 3);
        chk({a_dout, b_dout}, {32'hcd, 32'hab});
        // port a din, dout, waddr and we registered
        apb(1, `CTRL_OFF, 32'h14);
        apb(1, `REGSEL_OFF, 32'h1b);
        wr(2'b01, 2'b11, 7, 32'h5a);
        wr(2'b01, 2'b11, 7, 32'h0);
        rd(2'b01, 7);
        chk(a_dout, 32'h5a);
        wr(2'b10, 2'b11, 7, 32'h99);
        rd(2'b00, 7);
        chk(a_dout, 32'h5a);
        rd(2'b01, 7);
        chk(a_dout, 32'h99);
        $display("ram done");
        apb(1, `CTRL_OFF, 32'h57);
        feed_u.put(2, 32'ha5, '1);
        feed_u.put(5, 32'ha5, '1);
        apb(1, `CAMDATA_OFF, 32'h50);
        apb(1, `CAMCARE_OFF, 32'hfffffff0);
        apb(1, `CAMCMD_OFF, 9);
        do apb(0, `STATUS_OFF, 0); while (r[0] !== 1'b0);
        srch(32'ha5);
        chk({hv, f, ad}, {2'b01, 5'd2});
        srch(32'h5f);
        chk(f, 1'b1);
        chk(ad, 5'd9);
        apb(1, `CTRL_OFF, 32'h17);
        srch(32'ha5);
        chk(v0, 16'h24);
        chk(ad, 5'd0);
        apb(1, `CTRL_OFF, 32'h16);
        feed_u.put(20, 32'h77, '1);
        srch(32'h77);
        chk({hv, h, v0, v1}, {2'b11, 16'h0, 16'h10});
        apb(1, `CTRL_OFF, 32'h56);
        srch(32'h77);
        chk({f, ad, v1}, {1'b1, 5'd20, 16'h0});
        glob_clr <= 1;
        @(posedge pclk) glob_clr <= 0;
        @(negedge pclk);
        chk({match_vec, match_found, match_addr, a_dout}, 0);
        $display("cam done");
        conclude();
    end
endmodule
